// ---- rst_ctrl_pkg.sv ----
// Constants for the reset, non-maskable interrupt and power-down controller.
// Assumes a single 100 MHz core clock and a plain strobe register port.
package rst_ctrl_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Internal reset sequence length
   localparam int unsigned RESET_SEQ_NS     = 10240;
   localparam int unsigned RESET_SEQ_CYCLES = RESET_SEQ_NS / CLK_PERIOD_NS;
   localparam int unsigned SEQ_CNT_W        = 11;

   // Register port
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;

   localparam logic [7:0] OFF_SYS_CONFIG  = 8'h00;
   localparam logic [7:0] OFF_XBUS_SELECT = 8'h04;
   localparam logic [7:0] OFF_RESET_FLAGS = 8'h08;
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK    = 8'h10;
   localparam logic [7:0] OFF_XBUS_ACTIVE = 8'h14;
   localparam logic [7:0] OFF_START_CFG   = 8'h18;

   // system_config_reg fields
   localparam int unsigned SC_XBUS_GLOBAL_EN = 2;
   localparam int unsigned SC_BIDIR_RESET_EN = 3;
   localparam logic [15:0] SYS_CONFIG_RESET  = 16'h0000;

   // xbus_module_select fields: 2K ram, 6K ram, first CAN, second CAN
   localparam int unsigned XS_RAM_2K  = 0;
   localparam int unsigned XS_RAM_6K  = 1;
   localparam int unsigned XS_CAN_1   = 2;
   localparam int unsigned XS_CAN_2   = 3;
   localparam int unsigned XS_W       = 4;
   localparam logic [3:0]  XBUS_SELECT_RESET = 4'h5;
   localparam logic [3:0]  XS_PIN_USERS      = 4'hc;

   // Reset flag bits
   localparam int unsigned RF_HW_LONG  = 0;
   localparam int unsigned RF_HW_SHORT = 1;
   localparam int unsigned RF_SW       = 2;
   localparam int unsigned RF_WDT      = 3;
   localparam int unsigned RF_W        = 4;

   // Interrupt status bits
   localparam int unsigned EV_NMI_EDGE   = 0;
   localparam int unsigned EV_PDN_ENTER  = 1;
   localparam int unsigned EV_PDN_REFUSE = 2;
   localparam int unsigned EV_W          = 3;

   // Startup configuration port
   localparam int unsigned CFG_W          = 16;
   localparam int unsigned CFG_BOOT_BIT   = 4;

   localparam int unsigned OE_GUARD = 3;

   typedef enum logic [3:0] {
      ST_SEQ  = 4'b0001,
      ST_INIT = 4'b0010,
      ST_RUN  = 4'b0100,
      ST_PDN  = 4'b1000
   } ctrl_state_t;
endpackage

// ---- reset_nmi_powerdown_ctrl.sv ----
// Reset sequencer with reset indication, NMI trap request, power down entry,
// bidirectional reset pin and expansion-bus module enables.
// Assumes pins and the startup port are asynchronous; CPU strobes are on core_clk_in.
// Contract
// - reset_indication_out low during hardware, software or watchdog reset.
// - reset_indication_out stays low after reset until end-of-init instruction.
// - Falling edge on NMI pin raises a trap request to the CPU; here only in ST_RUN, so none before end-of-init or in power down.
// - Power down entered only if NMI pin low when the instruction runs.
// - NMI high at power down instruction: request ignored, keep running.
// - Bidirectional reset enable locked after end-of-init, cleared by any reset.
// - Bidirectional mode pulls reset pin low during the whole reset sequence.
// - Bidirectional mode: reset flags always report a long hardware reset.
// - Bidirectional mode latches startup port; boot loader when boot bit low.
// - Bidirectional mode stretches short hardware reset to full sequence length.
// - Expansion modules enabled only when selected and global enable set.
// - Disabled expansion modules claim no address space and no pins.
// - Module select resets to 2 KByte extension RAM plus first CAN.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
module reset_nmi_powerdown_ctrl
   import rst_ctrl_pkg::*;
(
   input  wire logic              core_clk_in,
   input  wire logic              reset_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   input  wire logic              reset_input_pin_in,
   output logic                   reset_input_pin_out,
   output logic                   reset_input_pin_oe_out,
   input  wire logic              nonmaskable_irq_in,
   input  wire logic [CFG_W-1:0]  startup_config_port_in,
   input  wire logic              sw_reset_req_in,
   input  wire logic              wdt_reset_req_in,
   input  wire logic              end_of_init_instr_in,
   input  wire logic              power_down_instr_in,
   output logic                   reset_indication_out,
   output logic                   system_reset_out,
   output logic                   nmi_trap_out,
   output logic                   power_down_out,
   output logic                   boot_loader_out,
   output logic      [XS_W-1:0]   xbus_addr_en_out,
   output logic      [XS_W-1:0]   xbus_pin_en_out,
   output logic                   irq_out
);

   ctrl_state_t          state_q, state_d;
   logic [1:0]           pin_sync_q, nmi_sync_q;
   logic [CFG_W-1:0]     cfg_sync1_q, cfg_sync2_q, cfg_q;
   logic                 nmi_prev_q;
   logic [SEQ_CNT_W-1:0] cnt_q;
   logic                 hw_src_q, bdr_act_q, long_q, end_of_init_instr_q, wdt_src_q;
   logic [OE_GUARD-1:0]  oe_hist_q;
   logic [15:0]          sys_config_q;
   logic [XS_W-1:0]      xsel_q;
   logic [RF_W-1:0]      rflags_q;
   logic [EV_W-1:0]      ev_stat_q, ev_mask_q;
   logic [DATA_W-1:0]    rdata_q;

   // Synchronised pin levels; first stage read only by the second
   wire pin_low  = ~pin_sync_q[1];
   wire nmi_lvl  = nmi_sync_q[1];
   wire nmi_fall = nmi_prev_q & ~nmi_lvl;

   // Our own drive on the open-drain reset pin echoes back through the synchroniser;
   // the guard window keeps that echo from starting a fresh reset.
   wire pin_guard = reset_input_pin_oe_out | (|oe_hist_q);
   wire hw_req    = pin_low & ~pin_guard;
   wire sw_req    = sw_reset_req_in & (state_q != ST_SEQ) & (state_q != ST_PDN);
   wire wdt_req   = wdt_reset_req_in & (state_q != ST_SEQ) & (state_q != ST_PDN);
   wire any_req   = (state_q != ST_SEQ) & (hw_req | sw_req | wdt_req);
   wire bdr_bit   = sys_config_q[SC_BIDIR_RESET_EN];

   // Without bidirectional mode a hardware reset lasts as long as the pin is low
   wire seq_done  = (hw_src_q & ~bdr_act_q) ? ~pin_low
                                            : (cnt_q == '0);

   wire pdn_ok     = power_down_instr_in & (state_q == ST_RUN) & ~nmi_lvl;
   wire pdn_refuse = power_down_instr_in & (state_q == ST_RUN) & nmi_lvl;

   // Register decode
   wire sel_cfg   = (reg_addr_in == OFF_SYS_CONFIG);
   wire sel_xsel  = (reg_addr_in == OFF_XBUS_SELECT);
   wire sel_rflg  = (reg_addr_in == OFF_RESET_FLAGS);
   wire sel_stat  = (reg_addr_in == OFF_IRQ_STATUS);
   wire sel_mask  = (reg_addr_in == OFF_IRQ_MASK);
   wire sel_xact  = (reg_addr_in == OFF_XBUS_ACTIVE);
   wire sel_start = (reg_addr_in == OFF_START_CFG);
   wire wr_cfg    = reg_wr_in & sel_cfg & (state_q != ST_SEQ);
   wire wr_xsel   = reg_wr_in & sel_xsel & (state_q != ST_SEQ);

   wire [XS_W-1:0]   xbus_active = xsel_q & {XS_W{sys_config_q[SC_XBUS_GLOBAL_EN]}};
   wire [EV_W-1:0]   ev_set      = {pdn_refuse, pdn_ok, nmi_fall & (state_q == ST_RUN)};
   wire [EV_W-1:0]   ev_clr      = (reg_wr_in & sel_stat) ? reg_wdata_in[EV_W-1:0] : '0;
   wire [DATA_W-1:0] rd_mux      =
        sel_cfg   ? sys_config_q :
        sel_xsel  ? {{(DATA_W-XS_W){1'b0}}, xsel_q} :
        sel_rflg  ? {{(DATA_W-RF_W){1'b0}}, rflags_q} :
        sel_stat  ? {{(DATA_W-EV_W){1'b0}}, ev_stat_q} :
        sel_mask  ? {{(DATA_W-EV_W){1'b0}}, ev_mask_q} :
        sel_xact  ? {{(DATA_W-XS_W){1'b0}}, xbus_active} :
        sel_start ? cfg_q[DATA_W-1:0] : '0;

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_SEQ:  if (seq_done) state_d = ST_INIT;
         ST_INIT: if (any_req) state_d = ST_SEQ;
                  else if (end_of_init_instr_in) state_d = ST_RUN;
         ST_RUN:  if (any_req) state_d = ST_SEQ;
                  else if (pdn_ok) state_d = ST_PDN;
         ST_PDN:  if (hw_req) state_d = ST_SEQ;
         default: state_d = ST_SEQ;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      pin_sync_q  <= {pin_sync_q[0], reset_input_pin_in};
      nmi_sync_q  <= {nmi_sync_q[0], nonmaskable_irq_in};
      cfg_sync1_q <= startup_config_port_in;
      cfg_sync2_q <= cfg_sync1_q;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_q    <= ST_INIT;
         nmi_prev_q <= 1'b1;
         oe_hist_q  <= '0;
      end else begin
         state_q    <= state_d;
         nmi_prev_q <= nmi_lvl;
         oe_hist_q  <= {oe_hist_q[OE_GUARD-2:0], reset_input_pin_oe_out};
      end
   end

   // Sequence counter, source capture and reset flags
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt_q     <= '0;
         hw_src_q  <= 1'b0;
         bdr_act_q <= 1'b0;
         long_q    <= 1'b0;
         rflags_q  <= '0;
      end else if (any_req || (state_q == ST_PDN && hw_req)) begin
         cnt_q     <= SEQ_CNT_W'(RESET_SEQ_CYCLES - 1);
         hw_src_q  <= hw_req;
         bdr_act_q <= bdr_bit;
         long_q    <= 1'b0;
         rflags_q  <= '0;
      end else if (state_q == ST_SEQ) begin
         if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
         if (cnt_q == '0 && pin_low) long_q <= 1'b1;
         if (seq_done) begin
            rflags_q[RF_HW_LONG]  <= bdr_act_q | (hw_src_q & long_q);
            rflags_q[RF_HW_SHORT] <= ~bdr_act_q & hw_src_q & ~long_q;
            rflags_q[RF_SW]       <= ~bdr_act_q & ~hw_src_q & ~wdt_src_q;
            rflags_q[RF_WDT]      <= ~bdr_act_q & ~hw_src_q & wdt_src_q;
         end
      end
   end

   // Configuration registers; any reset sequence returns them to defaults
   always_ff @(posedge core_clk_in) begin
      if (reset_in || state_q == ST_SEQ) begin
         sys_config_q <= SYS_CONFIG_RESET;
         xsel_q       <= XBUS_SELECT_RESET;
         end_of_init_instr_q      <= 1'b0;
      end else begin
         if (end_of_init_instr_in && state_q == ST_INIT) end_of_init_instr_q <= 1'b1;
         if (wr_cfg) begin
            sys_config_q <= reg_wdata_in;
            if (end_of_init_instr_q) sys_config_q[SC_BIDIR_RESET_EN] <= bdr_bit;
         end
         if (wr_xsel) xsel_q <= reg_wdata_in[XS_W-1:0];
      end
   end

   // Startup port latched at the end of a hardware or bidirectional reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cfg_q <= '0;
      end else if (state_q == ST_SEQ && seq_done && (hw_src_q || bdr_act_q)) begin
         cfg_q <= cfg_sync2_q;
      end
   end

   // Sticky events: a set in the same cycle as a clear wins
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ev_stat_q <= '0;
         ev_mask_q <= '0;
         rdata_q   <= '0;
      end else begin
         ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
         if (reg_wr_in && sel_mask) ev_mask_q <= reg_wdata_in[EV_W-1:0];
         rdata_q   <= reg_rd_in ? rd_mux : '0;
      end
   end

   // Watchdog source is recorded as soon as the request is taken
   always_ff @(posedge core_clk_in) begin
      if (reset_in) wdt_src_q <= 1'b0;
      else if (any_req) wdt_src_q <= wdt_req & ~hw_req;
   end

   assign reg_rdata_out          = rdata_q;
   assign reset_indication_out   = (state_q == ST_RUN) | (state_q == ST_PDN);
   assign system_reset_out       = (state_q == ST_SEQ);
   assign reset_input_pin_out    = 1'b0;
   assign reset_input_pin_oe_out = (state_q == ST_SEQ) & bdr_act_q;
   assign nmi_trap_out           = nmi_fall & (state_q == ST_RUN);
   assign power_down_out         = (state_q == ST_PDN);
   assign boot_loader_out        = ~cfg_q[CFG_BOOT_BIT];
   assign xbus_addr_en_out       = xbus_active;
   assign xbus_pin_en_out        = xbus_active & XS_PIN_USERS;
   assign irq_out                = |(ev_stat_q & ev_mask_q);

   a_reset_indication_out_seq_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_q == ST_SEQ) |-> !reset_indication_out)
      else $error("reset indication high during reset sequence");

   a_reset_indication_out_end_of_init_instr: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $rose(reset_indication_out) |-> $past(end_of_init_instr_in) && $past(state_q) == ST_INIT)
      else $error("reset indication released without end of init");

   a_nmi_trap_edge: assert property (@(posedge core_clk_in) disable iff (reset_in)
      nmi_trap_out |-> $past(nmi_sync_q[1]) && !nmi_sync_q[1])
      else $error("trap without falling nmi edge");

   a_pdn_entry: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (power_down_instr_in && state_q == ST_RUN && !nmi_sync_q[1] && !any_req)
      |=> power_down_out)
      else $error("power down not entered with nmi low");

   a_pdn_refused: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (power_down_instr_in && state_q == ST_RUN && nmi_sync_q[1])
      |=> !power_down_out ##0 ev_stat_q[EV_PDN_REFUSE])
      else $error("power down taken with nmi high");

   a_bdr_locked: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (end_of_init_instr_q && state_q != ST_SEQ) |=> $stable(sys_config_q[SC_BIDIR_RESET_EN]))
      else $error("bidirectional enable changed after end of init");

   a_bdr_pin_drive: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_q == ST_SEQ && bdr_act_q) |-> reset_input_pin_oe_out && !reset_input_pin_out)
      else $error("reset pin not pulled during bidirectional sequence");

   a_bdr_long_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_q == ST_SEQ && seq_done && bdr_act_q) |=> rflags_q == 4'h1)
      else $error("bidirectional reset not flagged long");

   a_bdr_stretch: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state_q == ST_SEQ && bdr_act_q && cnt_q != '0) |=> state_q == ST_SEQ)
      else $error("bidirectional reset sequence cut short");

   a_xbus_gate: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !sys_config_q[SC_XBUS_GLOBAL_EN] |-> xbus_addr_en_out == '0 && xbus_pin_en_out == '0)
      else $error("expansion module enabled without global enable");

   a_xsel_default: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $fell(system_reset_out) |-> xsel_q == 4'h5)
      else $error("module select default wrong after reset");

endmodule // reset_nmi_powerdown_ctrl

// ---- reset_board_model.sv ----
// Board side of the controller: open-drain reset line with pull-up, and the NMI source.
// Assumes the controller drives the reset line only through its output enable.
`timescale 1ns/100ps
module reset_board_model (
   input  wire logic board_low_in,
   input  wire logic dut_out_in,
   input  wire logic dut_oe_in,
   input  wire logic nmi_req_low_in,
   output logic      rst_pin_out,
   output logic      nmi_pin_out
);
   // Pull-up wins only while nobody pulls the line low
   assign rst_pin_out = !(board_low_in || (dut_oe_in && !dut_out_in));
   // Source holds the line low for as long as power down entry is wanted
   assign nmi_pin_out = !nmi_req_low_in;
endmodule // reset_board_model

// ---- reset_nmi_powerdown_ctrl_tb.sv ----
// Self-checking bench for the reset, NMI and power-down controller.
// Assumes the board model on the pins and a 100 MHz core clock.
`timescale 1ns/100ps
module reset_nmi_powerdown_ctrl_tb;
   import rst_ctrl_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, board_low = 1'b0, nmi_low = 1'b0;
   logic        swr = 1'b0, wdr = 1'b0, end_of_init_instr = 1'b0, pdn = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, cfg = 16'h0000, rdata, val;
   logic        pin_o, pin_oe, pin, nmi, rind, sysrst, trap, pdo, boot, irq;
   logic [3:0]  aen, pen, sel;
   int          err_count = 0, checked = 0, seed = 57049, n_rst, n_oe, n;

   always #5 clk = ~clk;

   reset_board_model u_board (.board_low_in(board_low), .dut_out_in(pin_o), .dut_oe_in(pin_oe),
      .nmi_req_low_in(nmi_low), .rst_pin_out(pin), .nmi_pin_out(nmi));

   reset_nmi_powerdown_ctrl u_dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .reset_input_pin_in(pin), .reset_input_pin_out(pin_o), .reset_input_pin_oe_out(pin_oe),
      .nonmaskable_irq_in(nmi), .startup_config_port_in(cfg), .sw_reset_req_in(swr),
      .wdt_reset_req_in(wdr), .end_of_init_instr_in(end_of_init_instr), .power_down_instr_in(pdn),
      .reset_indication_out(rind), .system_reset_out(sysrst), .nmi_trap_out(trap),
      .power_down_out(pdo), .boot_loader_out(boot), .xbus_addr_en_out(aen),
      .xbus_pin_en_out(pen), .irq_out(irq));

   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 check(rdata, exp, what);
   endtask

   task strobe(input int k);
      @(posedge clk);
      case (k)
         0: end_of_init_instr <= 1'b1;
         1: pdn <= 1'b1;
         2: swr <= 1'b1;
         default: wdr <= 1'b1;
      endcase
      @(posedge clk); {end_of_init_instr, pdn, swr, wdr} <= 4'h0;
      #1;
   endtask

   // Counts sequence cycles and cycles with the reset line driven
   task measure();
      int w;
      n_rst = 0; n_oe = 0; w = 0;
      while (sysrst !== 1'b1 && w < 3000) begin @(posedge clk); #1; w++; end
      while (sysrst === 1'b1 && n_rst < 3000) begin
         n_rst++; n_oe += (pin_oe === 1'b1);
         @(posedge clk); #1;
      end
   endtask

   task pin_pulse(input int len);
      @(posedge clk); board_low <= 1'b1;
      fork begin repeat (len) @(posedge clk); board_low <= 1'b0; end join_none
   endtask

   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFF_XBUS_SELECT, 16'h0005, "select after reset");
      rd_chk(8'h1c, 16'h0000, "unmapped read");
      check(16'(aen), 16'h0000, "addr enables without global");
      $display("test reset defaults done");
      cfg <= 16'($random(seed)) & 16'hffef;
      pin_pulse(1100);
      #100 check(16'(rind), 16'h0000, "indication in hw reset");
      measure();
      check(16'(n_oe), 16'h0000, "line driven without bidir");
      rd_chk(OFF_RESET_FLAGS, 16'h0001, "long hw flag");
      check(16'(boot), 16'h0001, "boot loader on low boot bit");
      rd_chk(OFF_START_CFG, cfg, "latched startup port");
      $display("test hw reset done");
      val = (16'($random(seed)) & 16'hfff7) | 16'h0004;
      wr_reg(OFF_SYS_CONFIG, val);
      rd_chk(OFF_SYS_CONFIG, val, "config readback");
      sel = 4'($random(seed));
      wr_reg(OFF_XBUS_SELECT, {12'h000, sel});
      #1 check(16'(aen), 16'(sel), "addr enables");
      check(16'(pen), 16'(sel & XS_PIN_USERS), "pin enables");
      wr_reg(OFF_SYS_CONFIG, 16'h0000);
      #1 check(16'(aen | pen), 16'h0000, "global enable off");
      repeat (10) @(posedge clk);
      check(16'(rind), 16'h0000, "indication before end of init");
      strobe(0);
      check(16'(rind), 16'h0001, "indication after end of init");
      $display("test config done");
      @(posedge clk); nmi_low <= 1'b1; n = 0;
      repeat (8) begin @(posedge clk); #1; n += (trap === 1'b1); end
      check(16'(n), 16'h0001, "one trap per falling edge");
      check(16'(irq), 16'h0000, "masked interrupt");
      wr_reg(OFF_IRQ_MASK, 16'h0007);
      #1 check(16'(irq), 16'h0001, "unmasked interrupt");
      rd_chk(OFF_IRQ_STATUS, 16'h0001, "nmi event");
      wr_reg(OFF_IRQ_STATUS, 16'h0001);
      #1 check(16'(irq), 16'h0000, "cleared interrupt");
      @(posedge clk); nmi_low <= 1'b0;
      repeat (5) @(posedge clk);
      strobe(1); repeat (2) @(posedge clk);
      check(16'({pdo, rind}), 16'h0001, "refused power down");
      rd_chk(OFF_IRQ_STATUS, 16'h0004, "refusal event");
      wr_reg(OFF_IRQ_STATUS, 16'h0004);
      @(posedge clk); nmi_low <= 1'b1;
      repeat (5) @(posedge clk);
      strobe(1); repeat (2) @(posedge clk);
      check(16'(pdo), 16'h0001, "power down entered");
      rd_chk(OFF_IRQ_STATUS, 16'h0003, "entry events");
      $display("test nmi and power down done");
      @(posedge clk); nmi_low <= 1'b0;
      pin_pulse(20);
      measure();
      check(16'({pdo, rind}), 16'h0000, "power down left by reset");
      rd_chk(OFF_RESET_FLAGS, 16'h0002, "short hw flag");
      wr_reg(OFF_SYS_CONFIG, 16'h0008);
      strobe(0);
      wr_reg(OFF_SYS_CONFIG, 16'h0000);
      rd_chk(OFF_SYS_CONFIG, 16'h0008, "bidir locked");
      cfg <= cfg | 16'h0010;
      strobe(3);
      measure();
      check(16'(n_rst), 16'(RESET_SEQ_CYCLES), "wdt sequence length");
      check(16'(n_oe), 16'(RESET_SEQ_CYCLES), "line driven whole sequence");
      check(16'(rind), 16'h0000, "indication after wdt reset");
      rd_chk(OFF_RESET_FLAGS, 16'h0001, "bidir flags");
      rd_chk(OFF_SYS_CONFIG, 16'h0000, "bidir cleared");
      rd_chk(OFF_XBUS_SELECT, 16'h0005, "select reset");
      check(16'(boot), 16'h0000, "boot bit high latched");
      wr_reg(OFF_SYS_CONFIG, 16'h0008);
      pin_pulse(10);
      measure();
      check(16'(n_rst), 16'(RESET_SEQ_CYCLES), "short reset stretched");
      strobe(2);
      measure();
      check(16'(n_rst + n_oe * 2), 16'(RESET_SEQ_CYCLES), "sw sequence undriven");
      rd_chk(OFF_RESET_FLAGS, 16'h0004, "sw flag");
      $display("test bidir done");
      tally_and_finish();
   end
endmodule // reset_nmi_powerdown_ctrl_tb
